// ==== design/clbt_regs.svh ====
// Constants for the computer link block transfer unit: widths, field positions and reset values.
`ifndef CLBT_REGS_SVH
`define CLBT_REGS_SVH

`define CLBT_WORD_W      21
`define CLBT_HOST_W      18
`define CLBT_ADDR_W      15
`define CLBT_FLAG1_POS   18
`define CLBT_FLAG2_POS   19
`define CLBT_FLAG3_POS   20
`define CLBT_PAR_POS     20
`define CLBT_FIFO_DEPTH  4
`define CLBT_ADDR_RST    15'h0000
`define CLBT_WORD_RST    21'h000000
`define CLBT_HOST_RST    18'h00000

`endif

// ==== design/clbt_pkg.sv ====
// Types shared by the computer link block transfer unit.
package clbt_pkg;

  // Transfer sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    CLBT_IDLE  = 3'h1,
    CLBT_FETCH = 3'h2,
    CLBT_STORE = 3'h4
  } clbt_state_e;

  // Direction of the block in progress.
  typedef enum logic [1:0]
  {
    CLBT_RX = 2'h1,
    CLBT_TX = 2'h2
  } clbt_mode_e;

endpackage : clbt_pkg

// ==== design/clbt_parity.sv ====
// Word parity network: reports whether a word holds an odd number of ones.
module clbt_parity
#(
  parameter int W = 21
)
(
  input  wire logic [W-1:0] i_word,
  output logic              o_odd
);

  // Reduction across the whole word.
  always_comb
  begin
    o_odd = ^i_word;
  end

endmodule // clbt_parity

// ==== design/clbt_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
module clbt_fifo
#(
  parameter int W = 21,
  parameter int D = 4
)
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count.
  always_comb
  begin
    o_in_ready  = (count != CW'(D));
    o_out_valid = (count != '0);
    o_out_data  = mem[rd_ptr];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PW'(D - 1)) ? '0 : PW'(wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PW'(D - 1)) ? '0 : PW'(rd_ptr + 1'b1);
    end
    if (push && !pop)
    begin
      next_count = CW'(count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_count = CW'(count - 1'b1);
    end
  end

  // Pointers and storage.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push)
      begin
        mem[wr_ptr] <= i_in_data;
      end
    end
  end

endmodule // clbt_fifo

// ==== design/clbt_top.sv ====
// Computer link block transfer unit: moves words between a host processor and central memory.
`include "clbt_regs.svh"

// Overview of operation
// - Select-receive: bump address, clear data, fetch.
// - Receive stays busy until word captured.
// - Not-busy condition shown on status line.
// - Host read: hand word, bump, clear, refetch.
// - Transmit write: busy, bump address, store word.
// - Transmit busy clears after memory write done.
// - Select-transmit enters transmit mode.
// - Flag-clear resets flags one, two, parity.
// - Parity result reported; zero means error.
// - Read splits bits 18-1 and flags 19-21.
// - Write builds word with flags and parity.
// - Address-clear zeroes the address register.
module clbt_top
#(
  parameter int AW = `CLBT_ADDR_W,
  parameter int FD = `CLBT_FIFO_DEPTH
)
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_address_clear_fn,
  input  wire logic                     i_load_transfer_address_cmd,
  input  wire logic [AW-1:0]            i_load_addr,
  input  wire logic                     i_select_receive_fn,
  input  wire logic                     i_select_transmit_fn,
  input  wire logic                     i_flag_clear_fn,
  input  wire logic                     i_flag_one_set,
  input  wire logic                     i_flag_two_set,
  input  wire logic                     i_host_read,
  input  wire logic                     i_host_write,
  input  wire logic [`CLBT_HOST_W-1:0]  i_host_word,
  output logic [`CLBT_HOST_W-1:0]       o_host_word,
  output logic                          o_control_flag_one,
  output logic                          o_control_flag_two,
  output logic                          o_control_flag_three,
  output logic                          o_not_busy_status_line,
  output logic                          o_parity_status_input,
  output logic                          o_transmit_mode,
  output logic                          o_mem_req,
  output logic                          o_mem_we,
  output logic [AW-1:0]                 o_mem_addr,
  output logic [`CLBT_WORD_W-1:0]       o_mem_wdata,
  input  wire logic                     i_mem_ack,
  input  wire logic                     i_mem_rvalid,
  output logic                          o_mem_rready,
  input  wire logic [`CLBT_WORD_W-1:0]  i_mem_rdata
);

  import clbt_pkg::*;

  //----------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------
  clbt_state_e             state;
  clbt_state_e             next_state;
  clbt_mode_e              mode;
  clbt_mode_e              next_mode;
  logic [AW-1:0]           addr;
  logic [AW-1:0]           next_addr;
  logic [AW-1:0]           addr_inc;
  logic [`CLBT_WORD_W-1:0] data_reg;
  logic [`CLBT_WORD_W-1:0] next_data_reg;
  logic [`CLBT_HOST_W-1:0] next_host_word;
  logic                    flag1;
  logic                    flag2;
  logic                    flag3;
  logic                    next_flag1;
  logic                    next_flag2;
  logic                    next_flag3;
  logic                    parity_ok;
  logic                    next_parity_ok;
  logic                    not_busy;
  logic                    next_not_busy;
  logic                    mem_req;
  logic                    next_mem_req;
  logic                    mem_we;
  logic                    next_mem_we;
  logic [`CLBT_WORD_W-1:0] mem_wdata;
  logic [`CLBT_WORD_W-1:0] next_mem_wdata;
  logic                    fifo_valid;
  logic                    fifo_pop;
  logic [`CLBT_WORD_W-1:0] fifo_data;
  logic                    rx_odd;
  logic                    tx_odd;
  logic [`CLBT_WORD_W-2:0] tx_body;
  logic [`CLBT_WORD_W-1:0] tx_word;
  logic                    idle;
  logic                    start_rx;
  logic                    rd_rx;
  logic                    wr_tx;

  //----------------------------------------------------------------
  // Read data buffer and parity networks
  //----------------------------------------------------------------
  // Returned memory words queue here; the memory port stalls when it is full.
  clbt_fifo #(.W(`CLBT_WORD_W), .D(FD)) u_rx_fifo
  (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_mem_rvalid),
    .o_in_ready  (o_mem_rready),
    .i_in_data   (i_mem_rdata),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // Checks each word captured from memory.
  clbt_parity #(.W(`CLBT_WORD_W)) u_rx_parity
  (
    .i_word (fifo_data),
    .o_odd  (rx_odd)
  );

  // Computes the parity over the twenty outbound bits.
  clbt_parity #(.W(`CLBT_WORD_W - 1)) u_tx_parity
  (
    .i_word (tx_body),
    .o_odd  (tx_odd)
  );

  //----------------------------------------------------------------
  // Command decode
  //----------------------------------------------------------------
  // Commands other than flag set and flag clear are honoured only while idle; one is taken per cycle in a fixed priority.
  always_comb
  begin
    idle     = (state == CLBT_IDLE);
    addr_inc = AW'(addr + 1'b1);
    start_rx = idle && !i_address_clear_fn && !i_load_transfer_address_cmd && i_select_receive_fn;
    rd_rx    = idle && !i_address_clear_fn && !i_load_transfer_address_cmd && !i_select_receive_fn
               && !i_select_transmit_fn && i_host_read && (mode == CLBT_RX);
    wr_tx    = idle && !i_address_clear_fn && !i_load_transfer_address_cmd && !i_select_receive_fn
               && !i_select_transmit_fn && !i_host_read && i_host_write && (mode == CLBT_TX);
    fifo_pop = (state == CLBT_FETCH) && !mem_req;
    tx_body  = {flag2, flag1, i_host_word};
    tx_word  = {~tx_odd, tx_body};
  end

  //----------------------------------------------------------------
  // Transfer sequencer and outputs
  //----------------------------------------------------------------
  // Computes every next value of the sequencer, address, data and flag registers.
  always_comb
  begin
    next_state     = state;
    next_mode      = mode;
    next_addr      = addr;
    next_data_reg  = data_reg;
    next_host_word = o_host_word;
    next_flag1     = (flag1 && !i_flag_clear_fn) || i_flag_one_set;
    next_flag2     = (flag2 && !i_flag_clear_fn) || i_flag_two_set;
    next_flag3     = flag3;
    next_parity_ok = parity_ok && !i_flag_clear_fn;
    next_not_busy  = not_busy;
    next_mem_req   = mem_req;
    next_mem_we    = mem_we;
    next_mem_wdata = mem_wdata;
    case (state)
      CLBT_IDLE:
      begin
        if (i_address_clear_fn)
        begin
          next_addr = `CLBT_ADDR_RST;
        end
        else if (i_load_transfer_address_cmd)
        begin
          next_addr = i_load_addr;
        end
        else if (start_rx || rd_rx)
        begin
          if (rd_rx)
          begin
            next_host_word = data_reg[`CLBT_HOST_W-1:0];
            next_flag1     = data_reg[`CLBT_FLAG1_POS];
            next_flag2     = data_reg[`CLBT_FLAG2_POS];
            next_flag3     = data_reg[`CLBT_FLAG3_POS];
          end
          next_addr     = addr_inc;
          next_mode     = CLBT_RX;
          next_data_reg = `CLBT_WORD_RST;
          next_state    = CLBT_FETCH;
          next_not_busy = 1'b0;
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
        end
        else if (i_select_transmit_fn)
        begin
          next_mode     = CLBT_TX;
          next_data_reg = `CLBT_WORD_RST;
        end
        else if (wr_tx)
        begin
          next_data_reg  = tx_word;
          next_addr      = addr_inc;
          next_state     = CLBT_STORE;
          next_not_busy  = 1'b0;
          next_mem_req   = 1'b1;
          next_mem_we    = 1'b1;
          next_mem_wdata = tx_word;
        end
      end
      CLBT_FETCH:
      begin
        next_mem_req = mem_req && !i_mem_ack;
        if (fifo_pop && fifo_valid)
        begin
          next_data_reg  = fifo_data;
          next_parity_ok = rx_odd;
          next_state     = CLBT_IDLE;
          next_not_busy  = 1'b1;
        end
      end
      CLBT_STORE:
      begin
        if (i_mem_ack)
        begin
          next_mem_req  = 1'b0;
          next_mem_we   = 1'b0;
          next_state    = CLBT_IDLE;
          next_not_busy = 1'b1;
        end
      end
      default:
      begin
        next_state    = CLBT_IDLE;
        next_not_busy = 1'b1;
        next_mem_req  = 1'b0;
        next_mem_we   = 1'b0;
      end
    endcase
  end

  // Registers the sequencer; the unit comes up idle, in receive mode, with flags clear.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state       <= CLBT_IDLE;
      mode        <= CLBT_RX;
      addr        <= `CLBT_ADDR_RST;
      data_reg    <= `CLBT_WORD_RST;
      o_host_word <= `CLBT_HOST_RST;
      flag1       <= 1'b0;
      flag2       <= 1'b0;
      flag3       <= 1'b0;
      parity_ok   <= 1'b0;
      not_busy    <= 1'b1;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_wdata   <= `CLBT_WORD_RST;
    end
    else
    begin
      state       <= next_state;
      mode        <= next_mode;
      addr        <= next_addr;
      data_reg    <= next_data_reg;
      o_host_word <= next_host_word;
      flag1       <= next_flag1;
      flag2       <= next_flag2;
      flag3       <= next_flag3;
      parity_ok   <= next_parity_ok;
      not_busy    <= next_not_busy;
      mem_req     <= next_mem_req;
      mem_we      <= next_mem_we;
      mem_wdata   <= next_mem_wdata;
    end
  end

  // All outputs except o_mem_rready are flip-flop values passed out unchanged.
  assign o_control_flag_one     = flag1;
  assign o_control_flag_two     = flag2;
  assign o_control_flag_three   = flag3;
  assign o_not_busy_status_line = not_busy;
  assign o_parity_status_input  = parity_ok;
  assign o_transmit_mode        = mode[1]; // Transmit code is the upper one-hot bit.
  assign o_mem_req              = mem_req;
  assign o_mem_we               = mem_we;
  assign o_mem_addr             = addr;
  assign o_mem_wdata            = mem_wdata;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_rx_start_fetch: assert property (start_rx |=> !o_not_busy_status_line && o_mem_req && !o_mem_we
                                     && o_mem_addr == $past(addr_inc) && data_reg == '0)
    else $error("Select-receive did not start a fetch correctly.");
  a_rx_capture_ready: assert property ((state == CLBT_FETCH) && fifo_pop && fifo_valid
                                       |=> o_not_busy_status_line && data_reg == $past(fifo_data))
    else $error("Fetched word not captured when busy dropped.");
  a_busy_line_state: assert property (o_not_busy_status_line == (state == CLBT_IDLE))
    else $error("Status line disagrees with sequencer state.");
  a_rx_read_word: assert property (rd_rx |=> o_host_word == $past(data_reg[17:0])
                                   && o_control_flag_three == $past(data_reg[20]) && state == CLBT_FETCH)
    else $error("Host read did not hand over the word and refetch.");
  a_tx_write_store: assert property (wr_tx |=> o_mem_req && o_mem_we && !o_not_busy_status_line
                                     && o_mem_wdata[17:0] == $past(i_host_word) && o_mem_addr == $past(addr_inc))
    else $error("Transmit write did not start a store.");
  a_tx_busy_hold: assert property ((state == CLBT_STORE) && !i_mem_ack |=> !o_not_busy_status_line)
    else $error("Busy dropped before the memory write completed.");
  a_tx_mode_select: assert property (idle && !i_address_clear_fn && !i_load_transfer_address_cmd
                                     && !i_select_receive_fn && i_select_transmit_fn |=> o_transmit_mode)
    else $error("Select-transmit did not enter transmit mode.");
  a_flag_clear_act: assert property (i_flag_clear_fn && !rd_rx && !i_flag_one_set && !i_flag_two_set
                                     && !(state == CLBT_FETCH && fifo_pop && fifo_valid)
                                     |=> !o_control_flag_one && !o_control_flag_two && !o_parity_status_input)
    else $error("Flag-clear left a flag set.");
  a_parity_report: assert property ((state == CLBT_FETCH) && fifo_pop && fifo_valid
                                    |=> o_parity_status_input == ^$past(fifo_data))
    else $error("Parity status does not match the captured word.");
  a_tx_parity_odd: assert property (wr_tx |=> ^o_mem_wdata)
    else $error("Outbound word parity is not odd.");
  a_addr_clear_zero: assert property (idle && i_address_clear_fn |=> o_mem_addr == '0)
    else $error("Address-clear did not zero the address.");
  a_busy_no_glitch: assert property ($fell(o_not_busy_status_line) |=> !o_not_busy_status_line)
    else $error("Busy lasted a single cycle.");

  c_rx_word: cover property (rd_rx ##[1:20] o_not_busy_status_line);
  c_tx_word: cover property (wr_tx ##[1:20] o_not_busy_status_line);
  c_fifo_full: cover property (!o_mem_rready);

endmodule // clbt_top

// ==== testbench/clbt_mem_model.sv ====
// Central memory model that answers the unit's memory request port, promptly or after a set delay.
`include "clbt_regs.svh"

module clbt_mem_model
(
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset_n,
  input  wire logic [3:0]              i_delay,
  input  wire logic                    i_mem_req,
  input  wire logic                    i_mem_we,
  input  wire logic [14:0]             i_mem_addr,
  input  wire logic [`CLBT_WORD_W-1:0] i_mem_wdata,
  input  wire logic                    i_mem_rready,
  output logic                         o_mem_ack,
  output logic                         o_mem_rvalid,
  output logic [`CLBT_WORD_W-1:0]      o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`CLBT_WORD_W-1:0] mem [0:31];
  logic [3:0]              wait_cnt;
  logic                    read_pend;
  logic [4:0]              read_idx;

  // Fill the memory with a varied pattern so both parity results turn up.
  initial
  begin
    for (int i = 0; i < 32; i++)
    begin
      mem[i] = 21'(i * 32'h0A4C3 + 32'h0155);
    end
  end

  // Accept a request after the set delay, store or fetch, then stream the fetched word.
  // A released data bus shows the inverse of its last value, so stale data cannot pass as good.
  always @(posedge i_clk_sys)
  begin
    o_mem_ack <= 1'b0;
    if (!i_reset_n)
    begin
      wait_cnt     <= 4'h0;
      read_pend    <= 1'b0;
      o_mem_rvalid <= 1'b0;
      o_mem_rdata  <= 21'h000000;
    end
    else
    begin
      if (i_mem_req && !o_mem_ack && !read_pend && !o_mem_rvalid)
      begin
        if (wait_cnt >= i_delay)
        begin
          o_mem_ack <= 1'b1;
          wait_cnt  <= 4'h0;
          if (i_mem_we)
          begin
            mem[i_mem_addr[4:0]] <= i_mem_wdata;
          end
          else
          begin
            read_pend <= 1'b1;
            read_idx  <= i_mem_addr[4:0];
          end
        end
        else
        begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
      if (o_mem_rvalid && i_mem_rready)
      begin
        o_mem_rvalid <= 1'b0;
        o_mem_rdata  <= ~o_mem_rdata;
      end
      else if (read_pend)
      begin
        o_mem_rvalid <= 1'b1;
        o_mem_rdata  <= mem[read_idx];
        read_pend    <= 1'b0;
      end
    end
  end
endmodule // clbt_mem_model

// ==== testbench/test_computer_link_block_transfer.sv ====
// Self-checking testbench for the computer link block transfer unit.
`include "clbt_regs.svh"

module test_computer_link_block_transfer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [8:0] C_ACLR = 9'h001, C_LOAD = 9'h002, C_SRX = 9'h004, C_STX = 9'h008;
  localparam logic [8:0] C_FCLR = 9'h010, C_F1 = 9'h020, C_F2 = 9'h040, C_RD = 9'h080, C_WR = 9'h100;

  logic                    clk = 1'b0, rst_n = 1'b0;
  logic [8:0]              cmd = 9'h000;
  logic [17:0]             arg = 18'h00000;
  logic [3:0]              mem_delay = 4'h0;
  logic [17:0]             host_word;
  logic                    f1, f2, f3, nb, par, txm, req, we, ack, rvalid, rready;
  logic [14:0]             maddr;
  logic [`CLBT_WORD_W-1:0] wdata, rdata, w;
  int                      failures = 0, check_count = 0, cyc = 0;

  // ----------------------------------------------------------------
  // Clock, design and memory partner
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  clbt_top dut_u (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_address_clear_fn(cmd[0]), .i_load_transfer_address_cmd(cmd[1]),
    .i_load_addr(arg[14:0]), .i_select_receive_fn(cmd[2]), .i_select_transmit_fn(cmd[3]),
    .i_flag_clear_fn(cmd[4]), .i_flag_one_set(cmd[5]), .i_flag_two_set(cmd[6]), .i_host_read(cmd[7]),
    .i_host_write(cmd[8]), .i_host_word(arg), .o_host_word(host_word), .o_control_flag_one(f1),
    .o_control_flag_two(f2), .o_control_flag_three(f3), .o_not_busy_status_line(nb),
    .o_parity_status_input(par), .o_transmit_mode(txm), .o_mem_req(req), .o_mem_we(we),
    .o_mem_addr(maddr), .o_mem_wdata(wdata), .i_mem_ack(ack), .i_mem_rvalid(rvalid),
    .o_mem_rready(rready), .i_mem_rdata(rdata));

  clbt_mem_model mem_u (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_delay(mem_delay), .i_mem_req(req), .i_mem_we(we),
    .i_mem_addr(maddr), .i_mem_wdata(wdata), .i_mem_rready(rready), .o_mem_ack(ack),
    .o_mem_rvalid(rvalid), .o_mem_rdata(rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Pulses commands for one cycle and returns once the design's answer has settled.
  task automatic fire(input logic [8:0] v, input logic [17:0] a);
    @(posedge clk);
    cmd <= v;
    arg <= a;
    @(posedge clk);
    cmd <= 9'h000;
    #1;
  endtask

  // Polls the not-busy line under a bound, as the host program does.
  task automatic wait_idle();
    int n;
    n = 0;
    while (nb !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 200, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset leaves the unit idle in receive mode with cleared flags.
  task automatic t_reset();
    chk({nb, rready, txm, req, we, f1, f2, f3, par}, 9'h180);
    chk(maddr, 15'h0000);
  endtask

  // Receive block of three words with prompt and slow memory.
  task automatic t_receive();
    mem_delay <= 4'h5;
    fire(C_LOAD, 18'h00007);
    chk(maddr, 15'h0007);
    fire(C_ACLR, 18'h00000);
    chk(maddr, 15'h0000);
    fire(C_LOAD, 18'h0000F);
    chk(maddr, 15'h000F);
    fire(C_SRX, 18'h00000);
    chk(nb, 1'b0);
    chk({maddr, txm}, {15'h0010, 1'b0});
    repeat (3) @(posedge clk);
    #1;
    chk(nb, 1'b0);
    wait_idle();
    for (int k = 0; k < 3; k++)
    begin
      w = mem_u.mem[5'h10 + 5'(k)];
      chk(par, ^w);
      mem_delay <= 4'(k * 3);
      fire(C_RD, 18'h00000);
      chk(host_word, w[17:0]);
      chk({f3, f2, f1}, w[20:18]);
      chk({nb, txm}, 2'h0);
      chk(maddr, 15'h0011 + 15'(k));
      wait_idle();
    end
  endtask

  // Flag set and flag clear, then refusal of a read in transmit mode.
  task automatic t_flags();
    fire(C_F1 | C_F2, 18'h00000);
    chk({f2, f1}, 2'h3);
    fire(C_FCLR, 18'h00000);
    chk({f2, f1, par}, 3'h0);
    fire(C_LOAD, 18'h0001F);
    fire(C_STX, 18'h00000);
    wait_idle();
    chk({txm, maddr}, {1'b1, 15'h001F});
    fire(C_RD, 18'h00000);
    chk({nb, maddr}, {1'b1, 15'h001F});
  endtask

  // Two back-to-back stores, slow then prompt, with flags carried into the word.
  task automatic t_transmit();
    logic [17:0] d;
    for (int k = 0; k < 2; k++)
    begin
      d = (k == 0) ? 18'h2A5C3 : 18'h00001;
      mem_delay <= (k == 0) ? 4'h6 : 4'h0;
      fire((k == 0) ? C_F1 : C_F2, 18'h00000);
      fire(C_WR, d);
      chk({nb, req, we}, 3'h3);
      chk(maddr, 15'h0020 + 15'(k));
      if (k == 0)
      begin
        repeat (4) @(posedge clk);
        #1;
        chk(nb, 1'b0);
      end
      wait_idle();
      w = {~^{(k == 1), 1'b1, d}, (k == 1), 1'b1, d};
      chk(mem_u.mem[5'h00 + 5'(k)], w);
      chk(wdata, w);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_receive();
    t_flags();
    t_transmit();
    end_sim();
  end
endmodule // test_computer_link_block_transfer
